/* src/ssb_defs.vh */
// Constants for the line-interface signaling pin banks
`ifndef SSB_DEFS_VH
`define SSB_DEFS_VH

// Command byte layout
`define SSB_CMD_W 8
`define SSB_CMD_RW_BIT 7
`define SSB_CMD_ADDR_W 7

// Bank register addresses (command with write bit cleared)
`define SSB_ADDR_BANK_A 7'h29
`define SSB_ADDR_BANK_B 7'h2a
`define SSB_ADDR_BANK_C 7'h2b

// Register field positions
`define SSB_DIR_HI 7
`define SSB_DIR_LO 4
`define SSB_DATA_HI 3
`define SSB_DATA_LO 0

// Reset values: all pins input, data zero
`define SSB_DIR_RST 4'h0
`define SSB_DATA_RST 4'h0

// Ring control output select codes
`define SSB_RSEL_BANK_A 3'h3
`define SSB_RSEL_BANK_B 3'h4
`define SSB_RSEL_BANK_C 3'h5

// Serial frame: command byte then data byte
`define SSB_BIT_CNT_W 5
`define SSB_CMD_DONE 5'h08
`define SSB_FRAME_DONE 5'h10

`endif

/* src/ssb_signal_pins.v */
// Three banks of line-interface signaling pins behind the host control port
`timescale 1ns/1ps
`include "ssb_defs.vh"

// Summary of operation
// RULE1: Bank A register bits 7..4 set pin direction, channels 4..1; zero means input.
// RULE2: Bank A input pins read back as their level in bits 0..3, channel 1..4.
// RULE3: Bank A output pins are driven from written bits 0..3, channel 1..4.
// RULE4: Bank B register bits 7..4 set pin direction, channels 4..1; zero means input.
// RULE5: Bank B input pins read back as their level in bit channel minus one.
// RULE6: Bank B output pins are driven from written bits 0..3, channel 1..4.
// RULE7: Bank C register bits 7..4 set pin direction, channels 4..1; zero means input.
// RULE8: Bank C input pins read back as their sampled level in bits 0..3.
// RULE9: Bank C output pins are driven from written bits 0..3, channel 1..4.
// RULE10: Host commands: bit 7 set writes; codes 29h, 2ah, 2bh select banks A, B, C.
// RULE11: Ring control drives a bank pin only while it is output; code 011 selects A.
// RULE12: Writes to input pins are held, and driven once the pin turns output.
module ssb_signal_pins #(
	parameter CHANNELS = 4
) (
	// Clock and reset
	input wire core_clk_in,
	input wire rst_b_in,
	// Host control port (serial, external clock)
	input wire host_cs_b_in,
	input wire host_dclk_in,
	input wire host_din_in,
	output reg host_dout_out,
	output reg host_dout_oe_out,
	// Hardware ring-trip control
	input wire ring_trip_en_in,
	input wire [2:0] ring_output_select_in,
	input wire [CHANNELS-1:0] ring_ctl_in,
	// Bank A pins
	input wire [CHANNELS-1:0] signal_pin_bank_a_in,
	output reg [CHANNELS-1:0] signal_pin_bank_a_out,
	output reg [CHANNELS-1:0] signal_pin_bank_a_oe_out,
	// Bank B pins
	input wire [CHANNELS-1:0] signal_pin_bank_b_in,
	output reg [CHANNELS-1:0] signal_pin_bank_b_out,
	output reg [CHANNELS-1:0] signal_pin_bank_b_oe_out,
	// Bank C pins
	input wire [CHANNELS-1:0] signal_pin_bank_c_in,
	output reg [CHANNELS-1:0] signal_pin_bank_c_out,
	output reg [CHANNELS-1:0] signal_pin_bank_c_oe_out
);

	localparam NPIN = 3 * CHANNELS;
	localparam NHOST = 3;

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	wire [NPIN-1:0] pin_raw;
	reg [NPIN-1:0] pin_s1;
	reg [NPIN-1:0] pin_s2;
	reg [NPIN-1:0] pin_s3;
	reg [NPIN-1:0] pin_lvl;
	wire [NHOST-1:0] host_raw;
	reg [NHOST-1:0] host_s1;
	reg [NHOST-1:0] host_s2;
	reg [NHOST-1:0] host_s3;
	reg [NHOST-1:0] host_lvl;
	reg dclk_prev;

	assign pin_raw = {signal_pin_bank_c_in, signal_pin_bank_b_in, signal_pin_bank_a_in};
	assign host_raw = {host_din_in, host_dclk_in, host_cs_b_in};

	// Three stages; a level only moves once stages two and three agree,
	// so a single-cycle glitch on a slow line never reaches the registers
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_s1 <= {NPIN{1'b0}};
			pin_s2 <= {NPIN{1'b0}};
			pin_s3 <= {NPIN{1'b0}};
			pin_lvl <= {NPIN{1'b0}};
			host_s1 <= {NHOST{1'b1}};
			host_s2 <= {NHOST{1'b1}};
			host_s3 <= {NHOST{1'b1}};
			host_lvl <= {NHOST{1'b1}};
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
			host_s1 <= host_raw;
			host_s2 <= host_s1;
			host_s3 <= host_s2;
			host_lvl <= (host_s2 & host_s3) | (host_lvl & (host_s2 ^ host_s3));
		end
	end

	wire cs_act = ~host_lvl[0];
	wire dclk_rise = host_lvl[1] & ~dclk_prev;
	wire dclk_fall = ~host_lvl[1] & dclk_prev;
	wire din_lvl = host_lvl[2];

	// ------------------------------------------------------------
	// Bank registers
	// ------------------------------------------------------------
	reg [NPIN-1:0] dir;
	reg [NPIN-1:0] data;

	// Read value per bank: direction, then per-bit output data or pin level
	function [7:0] rd_bank;
		input [CHANNELS-1:0] d_dir;
		input [CHANNELS-1:0] d_dat;
		input [CHANNELS-1:0] d_pin;
		begin
			rd_bank = {d_dir, (d_dir & d_dat) | (~d_dir & d_pin)};
		end
	endfunction

	// ------------------------------------------------------------
	// Host command port
	// ------------------------------------------------------------
	reg [`SSB_BIT_CNT_W-1:0] bit_cnt;
	reg [`SSB_CMD_W-1:0] shift_in;
	reg [`SSB_CMD_W-1:0] shift_out;
	reg [`SSB_CMD_W-1:0] cmd;
	reg rd_phase;
	reg [1:0] bank_sel;
	reg [7:0] rd_val;
	wire [`SSB_CMD_W-1:0] cmd_next = {shift_in[`SSB_CMD_W-2:0], din_lvl};
	wire [`SSB_CMD_W-1:0] wr_byte = {shift_in[`SSB_CMD_W-2:0], din_lvl};

	// Decode the command byte just completed into a bank index
	always @* begin
		bank_sel = 2'd3;
		if (cmd_next[`SSB_CMD_ADDR_W-1:0] == `SSB_ADDR_BANK_A) begin // [RULE10]
			bank_sel = 2'd0;
		end else if (cmd_next[`SSB_CMD_ADDR_W-1:0] == `SSB_ADDR_BANK_B) begin
			bank_sel = 2'd1;
		end else if (cmd_next[`SSB_CMD_ADDR_W-1:0] == `SSB_ADDR_BANK_C) begin
			bank_sel = 2'd2;
		end
	end

	// Readback mux: inputs show pin level, outputs show held data
	always @* begin
		rd_val = 8'h00;
		case (bank_sel)
			2'd0: rd_val = rd_bank(dir[3:0], data[3:0], pin_lvl[3:0]); // [RULE2]
			2'd1: rd_val = rd_bank(dir[7:4], data[7:4], pin_lvl[7:4]); // [RULE5]
			2'd2: rd_val = rd_bank(dir[11:8], data[11:8], pin_lvl[11:8]); // [RULE8]
			default: rd_val = 8'h00;
		endcase
	end

	// Frame: eight command bits then eight data bits, MSB first on dclk rise.
	// Read data shifts out on dclk fall; deselect aborts any half frame.
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dclk_prev <= 1'b1;
			bit_cnt <= {`SSB_BIT_CNT_W{1'b0}};
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			cmd <= 8'h00;
			rd_phase <= 1'b0;
			host_dout_out <= 1'b0;
			host_dout_oe_out <= 1'b0;
			dir <= {3{`SSB_DIR_RST}};
			data <= {3{`SSB_DATA_RST}};
		end else begin
			dclk_prev <= host_lvl[1];
			if (!cs_act) begin
				bit_cnt <= {`SSB_BIT_CNT_W{1'b0}};
				rd_phase <= 1'b0;
				host_dout_oe_out <= 1'b0;
			end else if (dclk_rise && bit_cnt < `SSB_FRAME_DONE) begin
				bit_cnt <= bit_cnt + 1'b1;
				shift_in <= cmd_next;
				if (bit_cnt == `SSB_CMD_DONE - 1'b1) begin
					cmd <= cmd_next;
					// Read of a bank register: bit 7 clear
					if (!cmd_next[`SSB_CMD_RW_BIT] && bank_sel != 2'd3) begin // [RULE10]
						rd_phase <= 1'b1;
						shift_out <= rd_val;
					end
				end else if (bit_cnt == `SSB_FRAME_DONE - 1'b1 && cmd[`SSB_CMD_RW_BIT]) begin
					// Write keeps both nibbles; data held even for input pins
					if (cmd[`SSB_CMD_ADDR_W-1:0] == `SSB_ADDR_BANK_A) begin
						dir[3:0] <= wr_byte[`SSB_DIR_HI:`SSB_DIR_LO]; // [RULE1]
						data[3:0] <= wr_byte[`SSB_DATA_HI:`SSB_DATA_LO]; // [RULE12]
					end else if (cmd[`SSB_CMD_ADDR_W-1:0] == `SSB_ADDR_BANK_B) begin
						dir[7:4] <= wr_byte[`SSB_DIR_HI:`SSB_DIR_LO]; // [RULE4]
						data[7:4] <= wr_byte[`SSB_DATA_HI:`SSB_DATA_LO]; // [RULE12]
					end else if (cmd[`SSB_CMD_ADDR_W-1:0] == `SSB_ADDR_BANK_C) begin
						dir[11:8] <= wr_byte[`SSB_DIR_HI:`SSB_DIR_LO]; // [RULE7]
						data[11:8] <= wr_byte[`SSB_DATA_HI:`SSB_DATA_LO]; // [RULE12]
					end
				end
			end else if (dclk_fall && rd_phase) begin
				// Present next read bit; drive line only during the data byte
				host_dout_out <= shift_out[`SSB_CMD_W-1];
				shift_out <= {shift_out[`SSB_CMD_W-2:0], 1'b0};
				host_dout_oe_out <= 1'b1;
				if (bit_cnt == `SSB_FRAME_DONE) begin
					rd_phase <= 1'b0;
					host_dout_oe_out <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pin drivers with ring-control override
	// ------------------------------------------------------------
	wire ring_a = ring_trip_en_in && ring_output_select_in == `SSB_RSEL_BANK_A;
	wire ring_b = ring_trip_en_in && ring_output_select_in == `SSB_RSEL_BANK_B;
	wire ring_c = ring_trip_en_in && ring_output_select_in == `SSB_RSEL_BANK_C;

	// Registered so pins never glitch on a mux change; ring control only
	// reaches a pin whose enable is already set, inputs stay undriven
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			signal_pin_bank_a_out <= {CHANNELS{1'b0}};
			signal_pin_bank_b_out <= {CHANNELS{1'b0}};
			signal_pin_bank_c_out <= {CHANNELS{1'b0}};
			signal_pin_bank_a_oe_out <= {CHANNELS{1'b0}};
			signal_pin_bank_b_oe_out <= {CHANNELS{1'b0}};
			signal_pin_bank_c_oe_out <= {CHANNELS{1'b0}};
		end else begin
			signal_pin_bank_a_oe_out <= dir[3:0]; // [RULE1]
			signal_pin_bank_b_oe_out <= dir[7:4]; // [RULE4]
			signal_pin_bank_c_oe_out <= dir[11:8]; // [RULE7]
			signal_pin_bank_a_out <= dir[3:0] & (ring_a ? ring_ctl_in : data[3:0]); // [RULE3] [RULE11]
			signal_pin_bank_b_out <= dir[7:4] & (ring_b ? ring_ctl_in : data[7:4]); // [RULE6] [RULE11]
			signal_pin_bank_c_out <= dir[11:8] & (ring_c ? ring_ctl_in : data[11:8]); // [RULE9] [RULE11]
		end
	end

endmodule

/* verif/line_interface_circuit_signaling_pin_bank_tb.sv */
// Self-checking bench for the signaling pin banks
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module line_interface_circuit_signaling_pin_bank_tb;
	reg core_clk_in = 1'b0;
	reg rst_b_in = 1'b0;
	reg cs_b = 1'b1, dclk = 1'b1, din = 1'b1, ring_en = 1'b0, seen;
	reg [2:0] ring_sel = 3'h0;
	reg [3:0] ring_ctl = 4'h0;
	reg [11:0] lvl = 12'h000;
	reg [7:0] rd = 8'h00;
	reg [25:0] rows [0:3];
	wire dout, dout_oe;
	wire [11:0] pout, poe, pin;
	integer mismatches = 0, compares = 0, i;
	// Clock, 5 ns period
	always #2.5 core_clk_in = ~core_clk_in;
	ssb_signal_pins dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .host_cs_b_in(cs_b),
		.host_dclk_in(dclk), .host_din_in(din), .host_dout_out(dout), .host_dout_oe_out(dout_oe),
		.ring_trip_en_in(ring_en), .ring_output_select_in(ring_sel), .ring_ctl_in(ring_ctl),
		.signal_pin_bank_a_in(pin[3:0]), .signal_pin_bank_a_out(pout[3:0]),
		.signal_pin_bank_a_oe_out(poe[3:0]), .signal_pin_bank_b_in(pin[7:4]),
		.signal_pin_bank_b_out(pout[7:4]), .signal_pin_bank_b_oe_out(poe[7:4]),
		.signal_pin_bank_c_in(pin[11:8]), .signal_pin_bank_c_out(pout[11:8]),
		.signal_pin_bank_c_oe_out(poe[11:8]));
	ssb_line_model #(.CHANNELS(12)) u_line (.pin_drive_in(pout), .pin_oe_in(poe), .level_in(lvl),
		.wire_out(pin));
	// One host frame; phases of 6 cycles keep the slow serial clock legal
	task frame(input [7:0] cmd, input [7:0] dat, input integer nbits);
		integer k;
		begin
			seen = 1'b0;
			@(posedge core_clk_in) cs_b <= 1'b0;
			for (k = 0; k < nbits; k++) begin
				@(posedge core_clk_in) dclk <= 1'b0;
				din <= (k < 8) ? cmd[7-k] : dat[15-k];
				repeat (6) @(posedge core_clk_in) seen = seen | dout_oe;
				// Released line reads inverted, so an undriven bit never passes
				rd = {rd[6:0], dout_oe ? dout : ~dout};
				dclk <= 1'b1;
				repeat (6) @(posedge core_clk_in);
			end
			cs_b <= 1'b1;
			repeat (10) @(posedge core_clk_in);
		end
	endtask
	// Verdict and end of run
	task wrap_up;
		begin
			$display("compares %0d mismatches %0d", compares, mismatches);
			if (mismatches == 0 && compares > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	// Rows: bank, write byte, pin levels, expected read, expected drive
	initial begin
		rows[0] = {2'd0, 8'h5a, 4'h3, 8'h52, 4'h0};
		rows[1] = {2'd1, 8'hf6, 4'h9, 8'hf6, 4'h6};
		rows[2] = {2'd2, 8'h0c, 4'h5, 8'h05, 4'h0};
		rows[3] = {2'd0, 8'ha5, 4'hf, 8'ha5, 4'h0};
		repeat (5) @(posedge core_clk_in);
		`CHK("reset oe", 12'h000, poe)
		rst_b_in <= 1'b1;
		repeat (5) @(posedge core_clk_in);
		frame(8'h2b, 8'h00, 16);
		`CHK("reset read", 8'h00, rd)
		for (i = 0; i < 4; i++) begin
			lvl[rows[i][25:24]*4 +: 4] <= rows[i][15:12];
			frame(8'ha9 + rows[i][25:24], rows[i][23:16], 16);
			`CHK("write dout", 1'b0, seen)
			frame(8'h29 + rows[i][25:24], 8'h00, 16);
			`CHK("row read", rows[i][11:4], rd)
			`CHK("row out", rows[i][3:0], pout[rows[i][25:24]*4 +: 4])
			`CHK("row oe", rows[i][23:20], poe[rows[i][25:24]*4 +: 4])
		end
		// Unknown codes, then an aborted write, must leave everything alone
		frame(8'h2c, 8'h00, 16);
		`CHK("bad code dout", 1'b0, seen)
		frame(8'hac, 8'hff, 16);
		frame(8'h2b, 8'h00, 16);
		`CHK("bad write", 8'h05, rd)
		frame(8'ha9, 8'hff, 12);
		frame(8'h29, 8'h00, 16);
		`CHK("aborted write", 8'ha5, rd)
		`CHK("read dout", 1'b1, seen)
		// Ring control takes output pins only of the selected bank
		ring_en <= 1'b1;
		ring_sel <= 3'h3;
		ring_ctl <= 4'hf;
		repeat (3) @(posedge core_clk_in);
		`CHK("ring a", 4'ha, pout[3:0])
		ring_sel <= 3'h4;
		repeat (3) @(posedge core_clk_in);
		`CHK("ring b", 8'hf0, {pout[7:4], pout[3:0]})
		ring_sel <= 3'h6;
		repeat (3) @(posedge core_clk_in);
		`CHK("no ring", 4'h6, pout[7:4])
		frame(8'hab, 8'h30, 16);
		ring_sel <= 3'h5;
		repeat (3) @(posedge core_clk_in);
		`CHK("ring c", 4'h3, pout[11:8])
		// Reset in mid-run returns every pin to input
		ring_en <= 1'b0;
		rst_b_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		`CHK("mid reset oe", 12'h000, poe)
		rst_b_in <= 1'b1;
		repeat (5) @(posedge core_clk_in);
		frame(8'h29, 8'h00, 16);
		`CHK("mid reset read", 8'h0f, rd)
		wrap_up;
	end
endmodule

/* verif/ssb_line_model.sv */
// Line interface circuit model facing the signaling pin banks
`timescale 1ns/1ps
// ---------------------------------------------
// Pin wire resolution
// ---------------------------------------------
module ssb_line_model #(
	parameter CHANNELS = 12
) (
	// Device side
	input wire [CHANNELS-1:0] pin_drive_in,
	input wire [CHANNELS-1:0] pin_oe_in,
	// Circuit side
	input wire [CHANNELS-1:0] level_in,
	output wire [CHANNELS-1:0] wire_out
);
	// Device level wins where enabled; the circuit only sets released pins
	assign wire_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & level_in);
endmodule

/* verif/ssb_pins_sva.sv */
// Port-level checks for the signaling pin banks
`timescale 1ns/1ps
// ---------------------------------------------
// Checker
// ---------------------------------------------
module ssb_pins_sva #(
	parameter CHANNELS = 4
) (
	// Clock, reset and controls
	input wire core_clk_in,
	input wire rst_b_in,
	input wire host_cs_b_in,
	input wire host_dout_oe_out,
	input wire ring_trip_en_in,
	input wire [2:0] ring_output_select_in,
	input wire [CHANNELS-1:0] ring_ctl_in,
	// Pin outputs
	input wire [CHANNELS-1:0] signal_pin_bank_a_out,
	input wire [CHANNELS-1:0] signal_pin_bank_a_oe_out,
	input wire [CHANNELS-1:0] signal_pin_bank_b_out,
	input wire [CHANNELS-1:0] signal_pin_bank_b_oe_out,
	input wire [CHANNELS-1:0] signal_pin_bank_c_out,
	input wire [CHANNELS-1:0] signal_pin_bank_c_oe_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Input pins must never be driven, whatever data was written
	a_mask_bank_a: assert property ((signal_pin_bank_a_out & ~signal_pin_bank_a_oe_out) == 0)
		else $error("bank a drives an input pin");
	a_mask_bank_b: assert property ((signal_pin_bank_b_out & ~signal_pin_bank_b_oe_out) == 0)
		else $error("bank b drives an input pin");
	a_mask_bank_c: assert property ((signal_pin_bank_c_out & ~signal_pin_bank_c_oe_out) == 0)
		else $error("bank c drives an input pin");
	a_dout_idle: assert property (host_cs_b_in [*8] |-> !host_dout_oe_out)
		else $error("read data driven while deselected");
	a_dout_release: assert property ($rose(host_cs_b_in) |-> ##[1:6] !host_dout_oe_out)
		else $error("read data not released after deselect");
	// Without host traffic or ring control the pins hold
	a_pins_hold: assert property ((host_cs_b_in && !ring_trip_en_in) [*8] |=>
		$stable({signal_pin_bank_a_out, signal_pin_bank_a_oe_out, signal_pin_bank_b_out,
		signal_pin_bank_b_oe_out, signal_pin_bank_c_out, signal_pin_bank_c_oe_out}))
		else $error("pins changed without a write");
	a_ring_bank_a: assert property ((ring_trip_en_in && ring_output_select_in == 3'h3) |=>
		signal_pin_bank_a_out == ($past(ring_ctl_in) & signal_pin_bank_a_oe_out))
		else $error("bank a ring control wrong");
	a_ring_bank_b: assert property ((ring_trip_en_in && ring_output_select_in == 3'h4) |=>
		signal_pin_bank_b_out == ($past(ring_ctl_in) & signal_pin_bank_b_oe_out))
		else $error("bank b ring control wrong");
	a_ring_bank_c: assert property ((ring_trip_en_in && ring_output_select_in == 3'h5) |=>
		signal_pin_bank_c_out == ($past(ring_ctl_in) & signal_pin_bank_c_oe_out))
		else $error("bank c ring control wrong");
endmodule

bind ssb_signal_pins ssb_pins_sva #(.CHANNELS(CHANNELS)) u_sva (.core_clk_in(core_clk_in),
	.rst_b_in(rst_b_in), .host_cs_b_in(host_cs_b_in), .host_dout_oe_out(host_dout_oe_out),
	.ring_trip_en_in(ring_trip_en_in), .ring_output_select_in(ring_output_select_in),
	.ring_ctl_in(ring_ctl_in), .signal_pin_bank_a_out(signal_pin_bank_a_out),
	.signal_pin_bank_a_oe_out(signal_pin_bank_a_oe_out), .signal_pin_bank_b_out(signal_pin_bank_b_out),
	.signal_pin_bank_b_oe_out(signal_pin_bank_b_oe_out), .signal_pin_bank_c_out(signal_pin_bank_c_out),
	.signal_pin_bank_c_oe_out(signal_pin_bank_c_oe_out));
